//--- logic/qwrc_map.vh
// Register map, field positions, reset values and timing for the quad wiper control
`ifndef QWRC_MAP_VH
`define QWRC_MAP_VH

`define QW_ADDR_WIPER_LAST 8'h03
`define QW_ADDR_GP_FIRST 8'h04
`define QW_ADDR_GP_LAST 8'h06
`define QW_ADDR_RESERVED 8'h07
`define QW_ADDR_ACCESS 8'h08

`define QW_ACR_VOL_BIT 7
`define QW_ACR_PDC_BIT 6
`define QW_ACR_WIP_BIT 5

`define QW_ACR_VOL_RESET 1'b0
`define QW_ACR_PDC_RESET 1'b1
`define QW_WIPER_RESET 7'h40
`define QW_NV_DEFAULT 8'h40

`define QW_ID_PREFIX 4'hA

`define QW_MCLK_MHZ 50
`define QW_NV_WRITE_US 20000
`define QW_RECALL_CYCLES 16
`define QW_MBB_CYCLES 2

`endif

//--- logic/qwrc_sync.v
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module qwrc_sync #(
    parameter WIDTH = 1
) (
    input wire mclk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            meta_r <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- logic/qwrc_tap.v
// Make-before-break tap switch sequencer for one resistor channel
`include "qwrc_map.vh"
`default_nettype none
module qwrc_tap #(
    parameter MBB_CYCLES = `QW_MBB_CYCLES
) (
    input wire mclk,
    input wire rst,
    input wire [6:0] target,
    output reg [6:0] tap_main_r,
    output reg [6:0] tap_aux_r,
    output reg aux_on_r
);
    reg [7:0] hold_cnt_r;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            tap_main_r <= `QW_WIPER_RESET;
            tap_aux_r <= `QW_WIPER_RESET;
            aux_on_r <= 1'b0;
            hold_cnt_r <= 8'h00;
        end
        else if (!aux_on_r)
        begin
            if (target != tap_main_r)
            begin
                // New switch closes while the old one is still closed
                tap_aux_r <= target;
                aux_on_r <= 1'b1;
                hold_cnt_r <= 8'h00;
            end
        end
        else if (hold_cnt_r == MBB_CYCLES - 1)
        begin
            // Old switch opens only after the overlap
            tap_main_r <= tap_aux_r;
            aux_on_r <= 1'b0;
        end
        else
        begin
            hold_cnt_r <= hold_cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- logic/qwrc_top.v
// Serial slave, register bank, recall and shutdown control of the quad wiper block
//
// How it works
// - Wiper register holds 7-bit tap code, 00h low end, 7Fh high end.
// - Shutdown opens high-to-low path and ties each wiper to its low terminal.
// - Wiper registers are kept through shutdown, so taps return afterwards.
// - Normal operation only when shutdown pin high and control bit 6 set.
// - Serial interface and all registers stay usable during shutdown.
// - Data sampled on rising serial clock, changed after falling edge.
// - Address-select inputs form low three bits of slave address.
// - Respond only when received address bits match the select inputs.
// - On a tap change, close new switch before opening the old one.
// - At power-up all wiper registers start at 40h.
// - Once memory is readable, copy initial values into wiper registers.
// - Map: 0-3 wiper pairs, 4-6 general storage, 7 reserved, 8 access control.
// - Bit 7 picks non-volatile (0) or volatile-only (1) target; default 0.
// - Writing an initial value register also loads its wiper register.
// - Shutdown control bit defaults to 1; writing 0 shuts all channels.
// - Bit 5 is read-only, set while a non-volatile write runs.
// - While that flag is set, wiper and access control writes are rejected.
// - Pointer increments per data byte, wrapping from 08h to 00h.
// - Non-volatile write starts after STOP and lasts up to 20ms; storage here takes the data at once, only the busy flag follows STOP.
`include "qwrc_map.vh"
`default_nettype none
module qwrc_top #(
    parameter NV_WRITE_CYCLES = `QW_NV_WRITE_US * `QW_MCLK_MHZ,
    parameter RECALL_CYCLES = `QW_RECALL_CYCLES,
    parameter MBB_CYCLES = `QW_MBB_CYCLES
) (
    input wire mclk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire [2:0] address_select_inputs,
    input wire power_down_n,
    output wire [27:0] tap_main,
    output wire [27:0] tap_aux,
    output wire [3:0] tap_aux_on,
    output reg [3:0] path_open,
    output reg [3:0] wiper_to_low
);
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_RX = 5'b00010;
    localparam [4:0] S_ACK = 5'b00100;
    localparam [4:0] S_TX = 5'b01000;
    localparam [4:0] S_MACK = 5'b10000;

    wire [5:0] pins_s;
    wire scl_s;
    wire sda_s;
    wire pdn_n_s;
    wire [2:0] asel_s;

    reg scl_d_r;
    reg sda_d_r;
    reg [4:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [1:0] byte_cnt_r;
    reg rd_mode_r;
    reg [7:0] rx_r;
    reg [7:0] tx_r;
    reg [7:0] ptr_r;
    reg acr_vol_r;
    reg acr_pdc_r;
    reg wip_r;
    reg nv_dirty_r;
    reg [20:0] nv_cnt_r;
    reg recall_done_r;
    reg [7:0] recall_cnt_r;
    reg [7:0] nv_r [0:6];
    reg [6:0] wiper_r [0:3];
    reg [7:0] rd_data;
    reg [7:0] ptr_nxt;
    integer i;
    integer j;

    qwrc_sync #(
        .WIDTH(6)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in({scl_in, sda_in, power_down_n, address_select_inputs}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[5];
    assign sda_s = pins_s[4];
    assign pdn_n_s = pins_s[3];
    assign asel_s = pins_s[2:0];

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire id_match = (rx_r[7:1] == {`QW_ID_PREFIX, asel_s});

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : gen_chan
            qwrc_tap #(
                .MBB_CYCLES(MBB_CYCLES)
            ) u_tap (
                .mclk(mclk),
                .rst(rst),
                .target(wiper_r[g]),
                .tap_main_r(tap_main[7*g+6:7*g]),
                .tap_aux_r(tap_aux[7*g+6:7*g]),
                .aux_on_r(tap_aux_on[g])
            );
        end
    endgenerate

    // Non-volatile contents survive the power-on reset
    initial
    begin
        for (j = 0; j < 7; j = j + 1)
        begin
            nv_r[j] = `QW_NV_DEFAULT;
        end
    end

    always @*
    begin
        rd_data = 8'h00;
        if (ptr_r <= `QW_ADDR_WIPER_LAST)
        begin
            if (acr_vol_r)
                rd_data = {1'b0, wiper_r[ptr_r[1:0]]};
            else
                rd_data = nv_r[ptr_r[2:0]];
        end
        else if (ptr_r <= `QW_ADDR_GP_LAST)
        begin
            if (!acr_vol_r)
                rd_data = nv_r[ptr_r[2:0]];
        end
        else if (ptr_r == `QW_ADDR_ACCESS)
        begin
            rd_data[`QW_ACR_VOL_BIT] = acr_vol_r;
            rd_data[`QW_ACR_PDC_BIT] = acr_pdc_r;
            rd_data[`QW_ACR_WIP_BIT] = wip_r;
        end
        ptr_nxt = (ptr_r >= `QW_ADDR_ACCESS) ? 8'h00 : ptr_r + 8'h01;
    end

    // Non-volatile writes land at once; only the busy window follows STOP
    always @(posedge mclk)
    begin
        if (rst)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            state_r <= S_IDLE;
            bit_cnt_r <= 4'h0;
            byte_cnt_r <= 2'd0;
            rd_mode_r <= 1'b0;
            rx_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            acr_vol_r <= `QW_ACR_VOL_RESET;
            acr_pdc_r <= `QW_ACR_PDC_RESET;
            wip_r <= 1'b0;
            nv_dirty_r <= 1'b0;
            nv_cnt_r <= 21'd0;
            recall_done_r <= 1'b0;
            recall_cnt_r <= 8'h00;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            for (i = 0; i < 4; i = i + 1)
            begin
                wiper_r[i] <= `QW_WIPER_RESET;
            end
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            if (!recall_done_r)
            begin
                if (recall_cnt_r == RECALL_CYCLES - 1)
                begin
                    for (i = 0; i < 4; i = i + 1)
                    begin
                        wiper_r[i] <= nv_r[i][6:0];
                    end
                    recall_done_r <= 1'b1;
                end
                else
                    recall_cnt_r <= recall_cnt_r + 8'h01;
            end
            if (wip_r)
            begin
                if (nv_cnt_r == NV_WRITE_CYCLES - 1)
                    wip_r <= 1'b0;
                else
                    nv_cnt_r <= nv_cnt_r + 21'd1;
            end
            // START is ignored until the recall has finished
            if (!recall_done_r)
            begin
                state_r <= S_IDLE;
                sda_oe_n <= 1'b1;
            end
            else if (bus_start)
            begin
                state_r <= S_RX;
                bit_cnt_r <= 4'h0;
                byte_cnt_r <= 2'd0;
                sda_oe_n <= 1'b1;
            end
            else if (bus_stop)
            begin
                state_r <= S_IDLE;
                sda_oe_n <= 1'b1;
                if (nv_dirty_r)
                begin
                    wip_r <= 1'b1;
                    nv_cnt_r <= 21'd0;
                    nv_dirty_r <= 1'b0;
                end
            end
            else
            begin
                case (state_r)
                    S_RX:
                    begin
                        if (scl_rise && bit_cnt_r != 4'h8)
                        begin
                            rx_r <= {rx_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_r == 4'h8)
                        begin
                            bit_cnt_r <= 4'h0;
                            if (byte_cnt_r != 2'd2)
                                byte_cnt_r <= byte_cnt_r + 2'd1;
                            state_r <= S_ACK;
                            sda_oe_n <= 1'b0;
                            if (byte_cnt_r == 2'd0)
                            begin
                                rd_mode_r <= rx_r[0];
                                if (!id_match)
                                begin
                                    state_r <= S_IDLE;
                                    sda_oe_n <= 1'b1;
                                end
                            end
                            else if (byte_cnt_r == 2'd1)
                                ptr_r <= rx_r;
                            else
                            begin
                                ptr_r <= ptr_nxt;
                                // Writes accepted in shutdown as well
                                if (ptr_r <= `QW_ADDR_WIPER_LAST && !wip_r)
                                begin
                                    wiper_r[ptr_r[1:0]] <= rx_r[6:0];
                                    if (!acr_vol_r)
                                    begin
                                        nv_r[ptr_r[2:0]] <= rx_r;
                                        nv_dirty_r <= 1'b1;
                                    end
                                end
                                else if (ptr_r >= `QW_ADDR_GP_FIRST
                                    && ptr_r <= `QW_ADDR_GP_LAST && !acr_vol_r && !wip_r)
                                begin
                                    nv_r[ptr_r[2:0]] <= rx_r;
                                    nv_dirty_r <= 1'b1;
                                end
                                else if (ptr_r == `QW_ADDR_ACCESS && !wip_r)
                                begin
                                    acr_vol_r <= rx_r[`QW_ACR_VOL_BIT];
                                    acr_pdc_r <= rx_r[`QW_ACR_PDC_BIT];
                                end
                            end
                        end
                    end
                    S_ACK, S_MACK:
                    begin
                        if (state_r == S_MACK && scl_rise && sda_s)
                            state_r <= S_IDLE;
                        else if (scl_fall && rd_mode_r)
                        begin
                            tx_r <= rd_data;
                            sda_oe_n <= rd_data[7];
                            ptr_r <= ptr_nxt;
                            bit_cnt_r <= 4'h1;
                            state_r <= S_TX;
                        end
                        else if (scl_fall)
                        begin
                            sda_oe_n <= 1'b1;
                            bit_cnt_r <= 4'h0;
                            state_r <= S_RX;
                        end
                    end
                    S_TX:
                    begin
                        if (scl_fall && bit_cnt_r == 4'h8)
                        begin
                            sda_oe_n <= 1'b1;
                            state_r <= S_MACK;
                        end
                        else if (scl_fall)
                        begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe_n <= tx_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                    default:
                        sda_oe_n <= 1'b1;
                endcase
            end
        end
    end

    // Shutdown leaves wiper registers alone, so taps come back unchanged
    always @(posedge mclk)
    begin
        if (rst)
        begin
            path_open <= 4'h0;
            wiper_to_low <= 4'h0;
        end
        else
        begin
            path_open <= {4{~(pdn_n_s & acr_pdc_r)}};
            wiper_to_low <= {4{~(pdn_n_s & acr_pdc_r)}};
        end
    end
endmodule
`default_nettype wire

//--- verification/qwrc_checker.sv
// Assertion checker bound to the quad wiper control top
`default_nettype none
module qwrc_checker #(
    parameter MBB_CYCLES = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [2:0] address_select_inputs,
    input wire logic power_down_n,
    input wire logic [27:0] tap_main,
    input wire logic [27:0] tap_aux,
    input wire logic [3:0] tap_aux_on,
    input wire logic [3:0] path_open,
    input wire logic [3:0] wiper_to_low
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MBB_HI = MBB_CYCLES + 1;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Old switch may open only once the new one has closed
    sequence mbb_done_s;
        $fell(tap_aux_on[0]) && tap_main[6:0] == $past(tap_aux[6:0]);
    endsequence
    power_down_control_pin_a: assert property (!power_down_n [*5] |-> path_open == 4'hF)
        else $error("shutdown pin did not open the paths");
    power_down_control_agree_a: assert property (path_open == wiper_to_low &&
        (path_open == 4'h0 || path_open == 4'hF))
        else $error("shutdown outputs disagree");
    mbb_order_a: assert property ($changed(tap_main[6:0]) |->
        $past(tap_aux_on[0]) && tap_main[6:0] == $past(tap_aux[6:0]))
        else $error("main tap moved before second switch closed");
    mbb_release_a: assert property ($rose(tap_aux_on[0]) |-> ##[1:MBB_HI] mbb_done_s)
        else $error("second switch not released after tap move");
    ack_edge_a: assert property ($fell(sda_oe_n) |-> !$past(scl_in, 2))
        else $error("data driven while serial clock high");
    od_low_a: assert property (sda_out == 1'b0)
        else $error("open drain value not low");
    boot_mid_a: assert property ($fell(rst) |-> tap_main == {4{7'h40}})
        else $error("taps not mid scale after reset");
    boot_hold_a: assert property ($fell(rst) |-> (tap_main == {4{7'h40}}) [*8])
        else $error("taps left mid scale too early");
    // Idle second switch always sits on the main tap, on every channel
    aux_rest_a: assert property ((tap_aux_on[0] || tap_aux[6:0] == tap_main[6:0]) &&
        (tap_aux_on[1] || tap_aux[13:7] == tap_main[13:7]) &&
        (tap_aux_on[2] || tap_aux[20:14] == tap_main[20:14]) &&
        (tap_aux_on[3] || tap_aux[27:21] == tap_main[27:21]))
        else $error("second switch apart from main tap while idle");
endmodule
bind qwrc_top qwrc_checker #(.MBB_CYCLES(MBB_CYCLES)) i_qwrc_checker (
    .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_select_inputs(address_select_inputs),
    .power_down_n(power_down_n), .tap_main(tap_main), .tap_aux(tap_aux),
    .tap_aux_on(tap_aux_on), .path_open(path_open), .wiper_to_low(wiper_to_low));
`default_nettype wire

//--- verification/qwrc_i2c_master.sv
// Serial bus master model facing the quad wiper control slave
`default_nettype none
module qwrc_i2c_master (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Clock stands high between frames; repeated start first frees the line
    task automatic start;
        @(posedge mclk);
        #1;
        if (sda_line !== 1'b1)
        begin
            scl = 1'b0;
            #20 sda_drv = 1'b1;
            #140 scl = 1'b1;
            #80;
        end
        sda_drv = 1'b0;
        #80;
    endtask
    task automatic clk_bit(input logic b, output logic r);
        scl = 1'b0;
        #20 sda_drv = b;
        #60 scl = 1'b1;
        #78 r = sda_line;
        #2;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], r);
        clk_bit(1'b1, ack);
    endtask
    task automatic recv(output logic [7:0] b, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, b[i]);
        clk_bit(last, r);
    endtask
    task automatic stop;
        scl = 1'b0;
        #20 sda_drv = 1'b0;
        #60 scl = 1'b1;
        #80 sda_drv = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the quad wiper control block
`include "qwrc_map.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] sel = 3'b101;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic power_down_n = 1'b1;
    logic scl, sda_drv, sda_out, sda_oe_n;
    logic [27:0] tap_main, tap_aux;
    logic [3:0] tap_aux_on, path_open, wiper_to_low;
    logic [7:0] q[$];
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    // Pull-up wins unless a party pulls low
    wire logic sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
    always #10 mclk = ~mclk;
    qwrc_top #(.NV_WRITE_CYCLES(2000)) i_qwrc_top (.mclk(mclk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .address_select_inputs(sel), .power_down_n(power_down_n), .tap_main(tap_main),
        .tap_aux(tap_aux), .tap_aux_on(tap_aux_on), .path_open(path_open),
        .wiper_to_low(wiper_to_low));
    qwrc_i2c_master i_qwrc_i2c_master (.mclk(mclk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic send_ack(input logic [7:0] b);
        logic a;
        i_qwrc_i2c_master.send(b, a);
        chk("ack", a, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
        i_qwrc_i2c_master.start();
        send_ack({`QW_ID_PREFIX, sel, 1'b0});
        send_ack(a);
        foreach (d[i])
            send_ack(d[i]);
        i_qwrc_i2c_master.stop();
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic [7:0] b;
        i_qwrc_i2c_master.start();
        send_ack({`QW_ID_PREFIX, sel, 1'b0});
        send_ack(a);
        i_qwrc_i2c_master.start();
        send_ack({`QW_ID_PREFIX, sel, 1'b1});
        q = {};
        for (int i = 0; i < n; i++)
        begin
            i_qwrc_i2c_master.recv(b, i == n - 1);
            q.push_back(b);
        end
        i_qwrc_i2c_master.stop();
    endtask
    task automatic do_reset;
        @(posedge mclk);
        #1 rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 rst = 1'b0;
    endtask
    initial
    begin
        logic ack;
        do_reset();
        chk("boot taps", tap_main, {4{7'h40}});
        repeat (30) @(posedge mclk);
        rd(`QW_ADDR_ACCESS, 1);
        chk("acr reset", q[0], 8'h40);
        wr(8'h00, '{8'h15});
        rd(`QW_ADDR_ACCESS, 1);
        chk("acr busy", q[0], 8'h60);
        wr(`QW_ADDR_ACCESS, '{8'h9F});
        rd(`QW_ADDR_ACCESS, 1);
        chk("acr locked", q[0], 8'h60);
        repeat (2000) @(posedge mclk);
        chk("tap0", tap_main[6:0], 7'h15);
        wr(`QW_ADDR_ACCESS, '{8'h9F});
        rd(`QW_ADDR_ACCESS, 1);
        chk("acr vol", q[0], 8'h80);
        chk("shutdown", {path_open, wiper_to_low}, 8'hFF);
        wr(8'h01, '{8'h7F, 8'h00});
        rd(8'h01, 2);
        chk("wiper1", q[0], 8'h7F);
        chk("wiper2", q[1], 8'h00);
        chk("taps12", tap_main[20:7], {7'h00, 7'h7F});
        wr(`QW_ADDR_ACCESS, '{8'hC0});
        repeat (10) @(posedge mclk);
        chk("path back", path_open, 4'h0);
        chk("tap kept", tap_main[13:7], 7'h7F);
        #1 power_down_n = 1'b0;
        repeat (10) @(posedge mclk);
        chk("pin off", path_open, 4'hF);
        #1 power_down_n = 1'b1;
        repeat (10) @(posedge mclk);
        chk("pin on", path_open, 4'h0);
        rd(`QW_ADDR_ACCESS, 2);
        chk("wrap acr", q[0], 8'hC0);
        chk("wrap wiper0", q[1], 8'h15);
        wr(8'h04, '{8'hAA});
        wr(8'h07, '{8'h55});
        wr(`QW_ADDR_ACCESS, '{8'h40});
        // Storage write also starts a busy window, checked further down
        wr(8'h05, '{8'hA5});
        rd(8'h04, 4);
        foreach (q[i])
            chk("storage", q[i], i == 1 ? 8'hA5 : (i < 3 ? 8'h40 : 8'h00));
        i_qwrc_i2c_master.start();
        i_qwrc_i2c_master.send({`QW_ID_PREFIX, 3'b010, 1'b0}, ack);
        chk("foreign id", ack, 1'b1);
        i_qwrc_i2c_master.stop();
        @(posedge mclk);
        #1 sel = 3'b010;
        rd(`QW_ADDR_ACCESS, 1);
        chk("new id busy", q[0], 8'h60);
        i_qwrc_i2c_master.start();
        i_qwrc_i2c_master.send({`QW_ID_PREFIX, 3'b101, 1'b0}, ack);
        chk("old id", ack, 1'b1);
        i_qwrc_i2c_master.stop();
        do_reset();
        chk("reboot taps", tap_main, {4{7'h40}});
        repeat (30) @(posedge mclk);
        chk("recalled", tap_main, {{3{7'h40}}, 7'h15});
        stop_test();
    end
endmodule
`default_nettype wire
